// ### include/pci_target_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by the target port and the bench
// Notes: Definitions only
`ifndef PCI_TARGET_MAP_SVH
`define PCI_TARGET_MAP_SVH

`define CMD_IO_READ 4'h2
`define CMD_IO_WRITE 4'h3
`define CMD_MEM_READ 4'h6
`define CMD_MEM_WRITE 4'h7
`define CMD_CFG_READ 4'ha
`define CMD_CFG_WRITE 4'hb
`define CMD_MEM_READ_MULT 4'hc
`define CMD_MEM_READ_LINE 4'he
`define CMD_MEM_WRITE_INV 4'hf

`define CSR_MEM_ADDR_BITS 12
`define CSR_IO_ADDR_BITS 6
`define FLASH_ADDR_BITS 17
`define CSR_WORDS 16

`define FLASH_READ_NS 120
`define FLASH_WRITE_NS 200
`define CLK_PERIOD_NS 4
`define FLASH_READ_CYCLES \
    ((`FLASH_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_WRITE_CYCLES \
    ((`FLASH_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define EEPROM_LOAD_CYCLES 2048
`define CMD_REG_RESET 3'h0
`define BAR_RESET 32'h0000_0000

`endif

// ### include/pci_target_pkg.sv
// Purpose: Types shared by the target port
// Assumes: Nothing
// Notes: Constants live in the map header
package pci_target_pkg;

    // Transaction state, Gray coded along idle, decode, wait, data, turn
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_decode = 3'b001,
        st_wait = 3'b011,
        st_data = 3'b010,
        st_turn = 3'b110
    } tstate_t;

    // Which space an access hit
    typedef enum logic [2:0] {
        sp_none = 3'h0,
        sp_csr_mem = 3'h1,
        sp_csr_io = 3'h2,
        sp_flash = 3'h3,
        sp_cfg = 3'h4
    } space_t;

    // Initialization source ranked highest first
    typedef enum logic [2:0] {
        init_none = 3'h0,
        init_por = 3'h1,
        init_alt_pin = 3'h2,
        init_bus = 3'h3,
        init_bus_isolation_input = 3'h4,
        init_software = 3'h5,
        init_selective = 3'h6
    } init_src_t;

endpackage

// ### logic/pci_target_port.sv
// Purpose: Bus target port with initialization precedence
// Assumes: Bus pins synchronous to clk; active-low bus signals as _n
// Notes: Flash is an external parallel part with a fixed access time
//        Control space: 16 words repeated over 4 KB
//        Bases sit at config words 4 to 6
//        A zero base disables its space
`timescale 1ns/1ps
`default_nettype none
`include "pci_target_map.svh"

module pci_target_port
    import pci_target_pkg::*;
(
    input wire logic clk,                 // Bus clock, 250 MHz
    input wire logic resetn,              // Power-on reset, active low
    input wire logic alternate_reset_pin_n, // Alternate reset pin
    input wire logic bus_reset_n,         // Bus reset
    input wire logic bus_isolation_input_n, // Isolation pin
    input wire logic d3_to_d0,            // Power state return pulse
    input wire logic software_reset,      // Software reset command
    input wire logic selective_reset,     // Selective reset command
    input wire logic frame_n,             // Initiator frame
    input wire logic irdy_n,              // Initiator ready
    input wire logic idsel,               // Config select
    input wire logic [3:0] cbe_n,         // Command / byte enables
    input wire logic [31:0] ad_in,        // Address/data in
    output logic [31:0] ad_out,           // Address/data out
    output logic ad_oe,                   // Address/data drive enable
    output logic trdy_n,                  // Target ready
    output logic stop_n,                  // Target stop
    output logic devsel_n,                // Device select
    output logic ctl_oe,                  // Drive enable of target lines
    output logic [16:0] flash_addr,       // Flash address
    output logic [7:0] flash_wdata,       // Flash write byte
    input wire logic [15:0] flash_rdata,  // Flash read data
    output logic flash_ce_n,              // Flash chip enable
    output logic flash_we_n,              // Flash write strobe
    output logic flash_oe_n,              // Flash output enable
    output logic eeprom_loaded,           // EEPROM load complete
    output logic [2:0] init_source,       // Last init source taken
    output logic [31:0] csr_mem_base,     // Control memory base
    output logic [31:0] csr_io_base,      // Control I/O base
    output logic [31:0] flash_base        // Flash window base
);

    // Cycle counts
    localparam logic [11:0] LOAD_CYCLES = 12'(`EEPROM_LOAD_CYCLES);
    localparam logic [7:0] FRD_CYCLES = 8'(`FLASH_READ_CYCLES);
    localparam logic [7:0] FWR_CYCLES = 8'(`FLASH_WRITE_CYCLES);

    // Reset release synchroniser
    logic rst_s1;
    logic rst_s2;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // Highest-ranked active source wins
    function automatic init_src_t pick_source(input logic por,
            input logic alt, input logic bus, input logic iso,
            input logic sw, input logic sel);
        if (por) pick_source = init_por;
        else if (alt) pick_source = init_alt_pin;
        else if (bus) pick_source = init_bus;
        else if (iso) pick_source = init_bus_isolation_input;
        else if (sw) pick_source = init_software;
        else if (sel) pick_source = init_selective;
        else pick_source = init_none;
    endfunction

    init_src_t src;
    logic clr_eeprom;
    logic clr_cfg;
    logic clr_state;
    always_comb begin
        src = pick_source(!rst_s2, !alternate_reset_pin_n, !bus_reset_n,
            !bus_isolation_input_n, software_reset, selective_reset);
        clr_eeprom = src inside {init_por, init_alt_pin, init_bus,
            init_bus_isolation_input};
        clr_cfg = clr_eeprom || d3_to_d0;
        clr_state = clr_cfg || src inside {init_software,
            init_selective};
    end

    // Record the source taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) init_source <= 3'(init_por);
        else if (src != init_none) init_source <= 3'(src);
    end

    // EEPROM auto-load timer; ends the retry period
    logic [11:0] load_cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            load_cnt <= 12'h000;
            eeprom_loaded <= 1'b0;
        end else if (clr_eeprom) begin
            load_cnt <= 12'h000;
            eeprom_loaded <= 1'b0;
        end else if (!eeprom_loaded) begin
            load_cnt <= load_cnt + 12'h001;
            eeprom_loaded <= (load_cnt == LOAD_CYCLES - 12'h001);
        end
    end

    // Address decode helpers
    function automatic logic hit(input logic [31:0] a,
            input logic [31:0] base, input int bits);
        logic [31:0] m;
        m = 32'hffff_ffff << bits;
        hit = (base != 32'h0) && ((a & m) == (base & m));
    endfunction

    // Either of two command codes
    function automatic logic is_cmd(input logic [3:0] c,
            input logic [3:0] a, input logic [3:0] b);
        is_cmd = (c == a) || (c == b);
    endfunction

    // Transaction sequencer
    tstate_t state;
    space_t space;
    logic is_write;
    logic [5:0] addr;
    logic [7:0] wait_cnt;
    logic [31:0] csr_mem [`CSR_WORDS];
    logic [3:0] cmd;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic cfg_cmd;
    logic bad_flash;
    always_comb begin
        cmd = ~cbe_n;
        mem_rd = (cbe_n == `CMD_MEM_READ) || (cbe_n == `CMD_MEM_READ_MULT)
            || (cbe_n == `CMD_MEM_READ_LINE);
        mem_wr = is_cmd(cbe_n, `CMD_MEM_WRITE, `CMD_MEM_WRITE_INV);
        io_rd = (cbe_n == `CMD_IO_READ);
        io_wr = (cbe_n == `CMD_IO_WRITE);
        cfg_cmd = idsel && is_cmd(cbe_n, `CMD_CFG_READ, `CMD_CFG_WRITE);
        // Flash lanes: byte or halfword reads, single byte writes
        bad_flash = is_write ? !(cmd == 4'h1 || cmd == 4'h2 ||
            cmd == 4'h4 || cmd == 4'h8)
            : !(cmd == 4'h1 || cmd == 4'h2 || cmd == 4'h4 ||
            cmd == 4'h8 || cmd == 4'h3 || cmd == 4'hc);
    end

    // Address phase capture and state walk
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= st_idle;
            space <= sp_none;
            is_write <= 1'b0;
            addr <= 6'h00;
            wait_cnt <= 8'h00;
            flash_addr <= 17'h00000;
        end else if (clr_state) begin
            state <= st_idle;
            space <= sp_none;
        end else begin
            unique case (state)
                st_idle: begin
                    if (!frame_n) begin
                        // Each space uses its own base
                        if (cfg_cmd) space <= sp_cfg;
                        else if ((mem_rd || mem_wr) && hit(ad_in,
                                csr_mem_base, `CSR_MEM_ADDR_BITS))
                            space <= sp_csr_mem;
                        else if ((io_rd || io_wr) && hit(ad_in,
                                csr_io_base, `CSR_IO_ADDR_BITS))
                            space <= sp_csr_io;
                        else if ((mem_rd || mem_wr) && hit(ad_in,
                                flash_base, `FLASH_ADDR_BITS))
                            space <= sp_flash;
                        else space <= sp_none;
                        is_write <= mem_wr || io_wr || cbe_n[0];
                        addr <= ad_in[7:2];
                        flash_addr <= ad_in[16:0];
                        state <= st_decode;
                    end
                end
                st_decode: begin
                    // Flash loads its wait count
                    if (space == sp_none) state <= st_idle;
                    else if (space == sp_flash) begin
                        wait_cnt <= is_write ? FWR_CYCLES : FRD_CYCLES;
                        state <= st_wait;
                    end else state <= st_data;
                end
                st_wait: begin
                    // Bad lanes skip the wait
                    if (bad_flash && wait_cnt == (is_write ? FWR_CYCLES
                            : FRD_CYCLES)) begin
                        wait_cnt <= 8'h00;
                        state <= st_data;
                    end else if (wait_cnt == 8'h01) state <= st_data;
                    else wait_cnt <= wait_cnt - 8'h01;
                end
                st_data: begin
                    // Retry or completed data phase ends the transfer
                    if (space == sp_cfg && !eeprom_loaded) state <= st_turn;
                    else if (!irdy_n) state <= st_turn;
                end
                st_turn: state <= st_idle;
                default: state <= st_idle;
            endcase
        end
    end

    // Target line terms; no retry bookkeeping kept
    logic retry;
    logic take;
    logic wait_done;
    logic sel_now;
    logic rdy_now;
    logic stop_now;
    always_comb begin
        retry = (space == sp_cfg) && !eeprom_loaded;
        take = (state == st_data) && !irdy_n && !retry;
        // Bad lanes end the flash wait at once
        wait_done = (state == st_wait) && (wait_cnt == 8'h01 ||
            (bad_flash && wait_cnt == (is_write ? FWR_CYCLES
            : FRD_CYCLES)));
        sel_now = (state == st_decode && space != sp_none) ||
            state == st_wait || (state == st_data && !take && !retry);
        // Ready never on a retry or a busy flash
        rdy_now = (state == st_decode && space != sp_none &&
            space != sp_flash && !retry) || wait_done ||
            (state == st_data && !take && !retry);
        // Stop only with ready, or alone on a retry
        stop_now = (state == st_decode && space != sp_none &&
            space != sp_flash) || wait_done ||
            (state == st_data && !take && !retry);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            devsel_n <= 1'b1;
            trdy_n <= 1'b1;
            stop_n <= 1'b1;
            ctl_oe <= 1'b0;
            ad_oe <= 1'b0;
            ad_out <= 32'h0000_0000;
        end else begin
            devsel_n <= !sel_now;
            // Ready only for real data, never on retry
            trdy_n <= !rdy_now;
            // Stop with the first data phase: disconnect or retry
            stop_n <= !stop_now;
            // Target lines driven while selected
            ctl_oe <= (state == st_decode && space != sp_none) ||
                state == st_wait || state == st_data;
            // Data lines driven on reads only
            ad_oe <= !is_write && ((state == st_decode &&
                space != sp_none && space != sp_flash) ||
                state == st_wait || (state == st_data && !take));
            // Read word at decode, flash data in wait
            if (state == st_decode && !is_write)
                ad_out <= (space == sp_csr_mem || space == sp_csr_io)
                    ? csr_mem[addr[3:0]] : 32'h0000_0000;
            else if (state == st_wait && !is_write)
                ad_out <= {flash_rdata, flash_rdata};
        end
    end

    // Control storage and base registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `CSR_WORDS; i++) csr_mem[i] <= 32'h0;
            csr_mem_base <= `BAR_RESET;
            csr_io_base <= `BAR_RESET;
            flash_base <= `BAR_RESET;
        end else if (clr_cfg) begin
            for (int i = 0; i < `CSR_WORDS; i++) csr_mem[i] <= 32'h0;
            csr_mem_base <= `BAR_RESET;
            csr_io_base <= `BAR_RESET;
            flash_base <= `BAR_RESET;
        end else if (take && is_write) begin
            // Write data valid with initiator ready
            if (space == sp_csr_mem || space == sp_csr_io)
                csr_mem[addr[3:0]] <= ad_in;
            else if (space == sp_cfg) begin
                if (addr == 6'h04) csr_mem_base <= ad_in & 32'hfffff000;
                if (addr == 6'h05) csr_io_base <= ad_in & 32'hffffffc1;
                if (addr == 6'h06) flash_base <= ad_in & 32'hfffe0000;
            end
        end
    end

    // Flash strobes held through the wait period
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flash_ce_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_wdata <= 8'h00;
        end else begin
            flash_ce_n <= !(state == st_wait && !bad_flash);
            flash_we_n <= !(state == st_wait && !bad_flash && is_write &&
                !irdy_n);
            flash_oe_n <= !(state == st_wait && !bad_flash && !is_write);
            // Write byte follows the enabled lane
            if (state == st_decode) flash_wdata <= ad_in[7:0];
            else if (state == st_wait && !irdy_n && is_write)
                flash_wdata <= cmd[1] ? ad_in[15:8] : (cmd[2] ?
                    ad_in[23:16] : (cmd[3] ? ad_in[31:24] : ad_in[7:0]));
        end
    end

endmodule
`default_nettype wire

// ### test/pci_target_monitor.sv
// Purpose: Protocol checker for the bus target port
// Assumes: Bound to pci_target_port, sees its ports only
// Notes: Latencies follow the hand-over contract
`timescale 1ns/1ps
`default_nettype none
module pci_target_monitor
    import pci_target_pkg::*;
(
    input wire logic clk, // Bus clock
    input wire logic resetn, // Power-on reset
    input wire logic alternate_reset_pin_n, // Pin reset
    input wire logic bus_reset_n, // Bus reset
    input wire logic bus_isolation_input_n, // Isolation
    input wire logic d3_to_d0, // Power return
    input wire logic software_reset, // Soft reset
    input wire logic frame_n, // Frame
    input wire logic irdy_n, // Initiator ready
    input wire logic idsel, // Config select
    input wire logic [3:0] cbe_n, // Command / enables
    input wire logic [31:0] ad_in, // Address/data
    input wire logic ad_oe, // Data drive
    input wire logic trdy_n, // Target ready
    input wire logic stop_n, // Stop
    input wire logic devsel_n, // Select
    input wire logic ctl_oe, // Line drive
    input wire logic flash_we_n, // Flash strobe
    input wire logic eeprom_loaded, // Load done
    input wire logic [2:0] init_source, // Init source
    input wire logic [31:0] csr_mem_base, // Memory base
    input wire logic [31:0] csr_io_base, // I/O base
    input wire logic [31:0] flash_base // Flash base
);
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Address decode of the three spaces
    wire logic mem_cmd = !idsel && cbe_n[3:1] == 3'b011;
    wire logic csr_hit = csr_mem_base != 0 &&
        ad_in[31:12] == csr_mem_base[31:12];
    wire logic io_hit = !idsel && cbe_n[3:1] == 3'b001 &&
        csr_io_base != 0 && ad_in[31:6] == csr_io_base[31:6];
    wire logic fl_hit = !idsel && flash_base != 0 &&
        ad_in[31:17] == flash_base[31:17];
    wire logic one_lane = cbe_n inside {4'he, 4'hd, 4'hb, 4'h7};

    // Address phases, flash writes qualified by their data-phase lanes
    sequence s_csr_mem;
        $fell(frame_n) && eeprom_loaded && mem_cmd && csr_hit;
    endsequence
    sequence s_csr_io;
        $fell(frame_n) && eeprom_loaded && io_hit;
    endsequence
    sequence s_cfg_early;
        $fell(frame_n) && !eeprom_loaded && idsel && cbe_n[3:1] == 3'b101;
    endsequence
    sequence s_fl_rd;
        $fell(frame_n) && eeprom_loaded && fl_hit && cbe_n == 4'h6;
    endsequence
    sequence s_fl_wr;
        $fell(frame_n) && eeprom_loaded && fl_hit && cbe_n == 4'h7 ##1
            one_lane;
    endsequence
    sequence s_fl_bad;
        $fell(frame_n) && eeprom_loaded && fl_hit && cbe_n == 4'h7 ##1
            !one_lane;
    endsequence

    a_csr_mem_nowait: assert property (s_csr_mem |-> ##2 (!devsel_n &&
        !trdy_n && !stop_n && ad_oe == !$past(cbe_n[0], 2)))
        else $error("control memory access not answered at once");
    a_csr_io_nowait: assert property (s_csr_io |-> ##2 (!devsel_n &&
        !trdy_n && !stop_n && ad_oe == !$past(cbe_n[0], 2)))
        else $error("control I/O access not answered at once");
    a_retry_shape: assert property (s_cfg_early |-> ##2
        (!devsel_n && !stop_n && trdy_n))
        else $error("early config cycle not retried");
    a_retry_no_ready: assert property (s_cfg_early |-> trdy_n[*6])
        else $error("ready seen during a retry");
    a_one_phase: assert property (!trdy_n && !irdy_n |=>
        trdy_n && stop_n && devsel_n)
        else $error("target held a second data phase");
    a_ready_stops: assert property (!trdy_n |-> !stop_n && !devsel_n)
        else $error("ready without disconnect");
    a_flash_rd_wait: assert property (s_fl_rd |->
        (trdy_n throughout ##28 1'b1) ##[1:8] !trdy_n)
        else $error("flash read wait wrong");
    a_flash_wr_wait: assert property (s_fl_wr |->
        (trdy_n throughout ##47 1'b1) ##[1:8] !trdy_n)
        else $error("flash write wait wrong");
    a_bad_lane_idle: assert property (s_fl_bad |-> flash_we_n[*8])
        else $error("flash strobed for a wide write");
    a_miss_silent: assert property ($fell(frame_n) && eeprom_loaded &&
        mem_cmd && !csr_hit && !fl_hit |-> ##1 devsel_n[*4])
        else $error("select for an unmapped address");
    a_sw_source: assert property (software_reset && bus_reset_n &&
        alternate_reset_pin_n && bus_isolation_input_n |->
        ##[1:4] init_source == init_software)
        else $error("software reset not recorded");
    a_pin_unloads: assert property (!bus_reset_n |->
        ##[1:4] !eeprom_loaded)
        else $error("bus reset kept the load flag");
    a_d3_clears: assert property (d3_to_d0 |->
        ##[1:4] csr_mem_base == 32'h0)
        else $error("power return kept the base");
    a_ctl_drive: assert property (!devsel_n |-> ctl_oe)
        else $error("select without line drive");
    a_stop_alone: assert property (!stop_n && trdy_n |->
        !$past(eeprom_loaded)) else $error("bare stop after load");
endmodule

bind pci_target_port pci_target_monitor i_mon (.*);
`default_nettype wire

// ### test/pci_host_model.sv
// Purpose: Bus initiator driving single data phase transfers
// Assumes: Target answers are registered outputs
// Notes: Released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module pci_host_model (
    input wire logic clk, // Bus clock
    input wire logic trdy_n, // Target ready
    input wire logic stop_n, // Target stop
    input wire logic devsel_n, // Device select
    input wire logic [31:0] ad_out, // Target data
    output logic frame_n, // Frame
    output logic irdy_n, // Initiator ready
    output logic idsel, // Config select
    output logic [3:0] cbe_n, // Command / enables
    output logic [31:0] ad_in // Address/data
);
    // Idle bus at time zero
    initial begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        idsel = 1'b0;
        cbe_n = 4'hf;
        ad_in = 32'h0;
    end

    // One transfer; dly holds off initiator ready that many clocks
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] a,
        input logic [3:0] be, input logic [31:0] wd, input logic sel,
        input int dly, output logic [31:0] rd, output int lat,
        output logic [2:0] ans);
        int n;
        @(posedge clk);
        frame_n <= 1'b0;
        ad_in <= a;
        cbe_n <= cmd;
        idsel <= sel;
        @(posedge clk);
        frame_n <= 1'b1;
        cbe_n <= be;
        idsel <= 1'b0;
        ad_in <= ~a;
        n = 0;
        repeat (dly) begin
            @(posedge clk);
            n++;
        end
        irdy_n <= 1'b0;
        ad_in <= cmd[0] ? wd : ~a;
        do begin
            @(posedge clk);
            n++;
        end while ((irdy_n || (trdy_n && stop_n)) && n < 80);
        rd = ad_out;
        lat = n;
        ans = {devsel_n, trdy_n, stop_n};
        irdy_n <= 1'b1;
        cbe_n <= ~be;
        ad_in <= ~ad_in;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench for the bus target port
// Assumes: Host model drives the bus, a flash model answers reads
// Notes: Answer codes are {devsel_n, trdy_n, stop_n}
`timescale 1ns/1ps
`default_nettype none
`include "pci_target_map.svh"
module tb_top;
    import pci_target_pkg::*;
    localparam logic [31:0] mbase = 32'h1000_0000;
    localparam logic [31:0] ibase = 32'h0000_2000;
    localparam logic [31:0] fbase = 32'h2000_0000;
    logic clk, resetn, alternate_reset_pin_n, bus_reset_n;
    logic bus_isolation_input_n, d3_to_d0, software_reset, selective_reset;
    logic frame_n, irdy_n, idsel, ad_oe, trdy_n, stop_n, devsel_n, ctl_oe;
    logic flash_ce_n, flash_we_n, flash_oe_n, eeprom_loaded;
    logic [3:0] cbe_n;
    logic [31:0] ad_in, ad_out, csr_mem_base, csr_io_base, flash_base, rd;
    logic [16:0] flash_addr;
    logic [7:0] flash_wdata;
    logic [15:0] flash_rdata;
    logic [2:0] init_source, ans;
    int lat, n_errors = 0, n_checks = 0, cyc = 0;

    pci_target_port i_dut (.*);
    pci_host_model i_host (.*);

    // Flash part: data while enabled, toggling junk otherwise
    assign flash_rdata = (flash_ce_n || flash_oe_n) ? {16{clk}} ^ 16'h5a5a
        : {flash_addr[7:0], ~flash_addr[7:0]};

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            print_verdict;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, lo);
        end
    endtask
    task automatic go(input logic [3:0] c, input logic [31:0] a,
        input logic [3:0] be, input logic [31:0] wd, input logic s,
        input int d);
        i_host.xfer(c, a, be, wd, s, d, rd, lat, ans);
    endtask
    task automatic wait_load;
        for (int i = 0; i < 2200 && eeprom_loaded !== 1'b1; i++)
            @(posedge clk);
        chk(eeprom_loaded, 1'b1);
    endtask

    // Config cycles before the load, at two addresses
    task automatic t_retry;
        go(`CMD_CFG_READ, 32'h10, 4'h0, 0, 1'b1, 0);
        chk(ans, 3'b010);
        chk_in(lat, 2, 2);
        go(`CMD_CFG_WRITE, 32'h14, 4'h0, ibase, 1'b1, 0);
        chk(ans, 3'b010);
        wait_load;
        chk(csr_io_base, 32'h0);
    endtask
    task automatic t_config;
        go(`CMD_CFG_WRITE, 32'h10, 4'h0, mbase, 1'b1, 0);
        chk(ans, 3'b000);
        go(`CMD_CFG_WRITE, 32'h14, 4'h0, ibase, 1'b1, 0);
        go(`CMD_CFG_WRITE, 32'h18, 4'h0, fbase, 1'b1, 0);
        chk(csr_mem_base, mbase);
        chk({csr_io_base[31:6], 6'h0}, ibase);
        chk(flash_base, fbase);
    endtask
    // Control space writes, reads with initiator waits, far corner
    task automatic t_csr;
        for (int i = 0; i < 4; i++) begin
            go(`CMD_MEM_WRITE, mbase + 4 * i, 4'h0, 32'hc0de_0000 + i, 0, 0);
            chk(ans, 3'b000);
            chk_in(lat, 2, 2);
        end
        for (int i = 0; i < 4; i++) begin
            go(`CMD_MEM_READ, mbase + 4 * i, 4'h0, 0, 0, i);
            chk(rd, 32'hc0de_0000 + i);
        end
        go(`CMD_IO_WRITE, ibase + 8, 4'h0, 32'h0bad_f00d, 0, 0);
        go(`CMD_IO_READ, ibase + 8, 4'h0, 0, 0, 0);
        chk(rd, 32'h0bad_f00d);
        go(`CMD_MEM_READ, mbase + 32'hffc, 4'h0, 0, 0, 0);
        chk(ans, 3'b000);
        go(`CMD_MEM_READ, mbase + 32'h1000, 4'h0, 0, 0, 0);
        chk(ans, 3'b111);
    endtask
    task automatic t_flash;
        go(`CMD_MEM_READ, fbase + 32'h1a4, 4'hc, 0, 0, 0);
        chk(ans, 3'b000);
        chk_in(lat, 31, 37);
        chk(rd[15:0], 16'ha45b);
        go(`CMD_MEM_WRITE, fbase + 32'h2c8, 4'he, 32'h37, 0, 0);
        chk(ans, 3'b000);
        chk_in(lat, 51, 57);
        chk(flash_wdata, 8'h37);
        chk(flash_addr, 17'h2c8);
        go(`CMD_MEM_WRITE, fbase + 32'h4, 4'hc, 32'h1234, 0, 0);
        chk(ans[1], 1'b0);
    endtask
    task automatic pulse(input logic s, input logic e, input logic d);
        @(posedge clk);
        software_reset <= s;
        selective_reset <= e;
        d3_to_d0 <= d;
        @(posedge clk);
        software_reset <= 1'b0;
        selective_reset <= 1'b0;
        d3_to_d0 <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic pin(input logic a, input logic b, input logic i,
        input logic [2:0] exp);
        @(posedge clk);
        alternate_reset_pin_n <= a;
        bus_reset_n <= b;
        bus_isolation_input_n <= i;
        repeat (4) @(posedge clk);
        alternate_reset_pin_n <= 1'b1;
        bus_reset_n <= 1'b1;
        bus_isolation_input_n <= 1'b1;
        repeat (4) @(posedge clk);
        chk(init_source, exp);
        chk(eeprom_loaded, 1'b0);
        chk(csr_mem_base, 32'h0);
        wait_load;
    endtask
    task automatic t_init;
        pulse(1'b1, 1'b1, 1'b0);
        chk(init_source, init_software);
        chk(csr_mem_base, mbase);
        chk(eeprom_loaded, 1'b1);
        pulse(1'b0, 1'b1, 1'b0);
        chk(init_source, init_selective);
        pin(1'b0, 1'b0, 1'b1, init_alt_pin);
        t_config;
        pulse(1'b0, 1'b0, 1'b1);
        chk(csr_mem_base, 32'h0);
        pin(1'b1, 1'b0, 1'b1, init_bus);
        pin(1'b1, 1'b1, 1'b0, init_bus_isolation_input);
    endtask

    initial begin
        resetn = 1'b0;
        alternate_reset_pin_n = 1'b1;
        bus_reset_n = 1'b1;
        bus_isolation_input_n = 1'b1;
        d3_to_d0 = 1'b0;
        software_reset = 1'b0;
        selective_reset = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        t_retry;
        t_config;
        t_csr;
        t_flash;
        t_init;
        print_verdict;
    end
endmodule
`default_nettype wire
